// File: sim/asra_host_model.sv
// Host serial master model that shifts whole frames on the four wire link.
`timescale 1ns/1ps
module asra_host_model (
   // Serial link
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   input  wire logic dout
);
   // The link clock stands low and the frame is closed between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b0;
   end

   // Shifts len bits MSB first at 80 ns per bit and captures dout at each falling edge.
   task automatic shift(input logic [31:0] tx, input int len, output logic [31:0] rx);
      rx = 32'h0;
      cs_n = 1'b0;
      for (int i = 31; i > 31 - len; i--) begin
         din = tx[i];
         #40;
         sclk = 1'b1;
         #40;
         sclk = 1'b0;
         rx = {rx[30:0], dout};
      end
      #40;
      cs_n = 1'b1;
      // An unselected data line shows the inverse so a stale value is never mistaken for data.
      din = ~din;
      // The frame stays closed for a while so that two frames never touch.
      #40;
   endtask
endmodule

// File: sim/asra_top_properties.sv
// Concurrent checks on the ports of the serial register access front end.
`timescale 1ns/1ps
module asra_top_properties (
   // Clock, reset and serial clock
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        sclk,
   // Serial output and result strobe
   input wire logic        dout,
   input wire logic        result_valid,
   // Control outputs
   input wire logic        power_down_bit,
   input wire logic [1:0]  input_channel_field,
   input wire logic [1:0]  cal_mode,
   input wire logic [2:0]  gain_code,
   input wire logic        unipolar,
   input wire logic        buffer_en,
   input wire logic        filter_sync,
   input wire logic [2:0]  rate_select,
   input wire logic [4:0]  clock_ctrl,
   input wire logic [23:0] cal_offset,
   input wire logic [23:0] cal_gain,
   // Status
   input wire logic        conversion_ready_flag
);
   logic        sclk_q, sclk_d, seen_q, seen_d, recent;
   logic [5:0]  quiet_q, quiet_d;
   logic [15:0] cfg;

   // Settings gathered in setup and clock register order.
   assign cfg = {cal_mode, gain_code, unipolar, buffer_en, filter_sync, clock_ctrl, rate_select};
   // A change caused by the link must follow a serial clock movement closely.
   assign recent = (sclk != sclk_q) || (quiet_q < 6'h10);

   // Counts core cycles since the serial clock last moved and notes any result.
   always_comb begin
      sclk_d = sclk;
      seen_d = seen_q | result_valid;
      quiet_d = (quiet_q == 6'h3F) ? quiet_q : quiet_q + 6'h01;
      if (sclk != sclk_q) begin
         quiet_d = 6'h00;
      end
   end

   // Registers the helper state.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q  <= 1'b0;
         seen_q  <= 1'b0;
         quiet_q <= 6'h3F;
      end else begin
         sclk_q  <= sclk_d;
         seen_q  <= seen_d;
         quiet_q <= quiet_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_release;
      $rose(reset_n);
   endsequence
   sequence s_ready_up;
      $rose(conversion_ready_flag);
   endsequence

   AST_RESET_CTRL: assert property (s_release |-> !power_down_bit && input_channel_field == 2'h0 && !dout)
      else $error("control outputs not idle after reset");
   AST_RESET_SETUP: assert property (s_release |-> cfg[15:8] == asra_pkg::SETUP_RESET)
      else $error("setup outputs wrong after reset");
   AST_RESET_CLOCK: assert property (s_release |-> cfg[7:0] == asra_pkg::CLOCK_RESET)
      else $error("clock outputs wrong after reset");
   AST_RESET_CAL: assert property (s_release |-> cal_offset == asra_pkg::CAL_RESET && cal_gain == 24'h000000)
      else $error("calibration words wrong after reset");
   AST_READY_CAUSE: assert property (s_ready_up |-> seen_q && recent)
      else $error("ready flag rose without a result");
   AST_CFG_SERIAL: assert property ($changed(cfg) |-> recent)
      else $error("settings changed without link activity");
   AST_MODE_SERIAL: assert property ($changed({power_down_bit, input_channel_field}) |-> recent)
      else $error("standby or channel changed without link activity");
   AST_CAL_SERIAL: assert property ($changed({cal_offset, cal_gain}) |-> recent)
      else $error("calibration word changed without link activity");
   AST_READY_CLEAR: assert property ($fell(conversion_ready_flag) |-> recent)
      else $error("ready flag cleared without a read");
   AST_DOUT_SERIAL: assert property ($changed(dout) |-> sclk != sclk_q || quiet_q < 6'h02)
      else $error("serial output moved without a serial clock edge");
endmodule

bind asra_top asra_top_properties u_asra_top_properties (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk),
   .dout(dout), .result_valid(result_valid), .power_down_bit(power_down_bit),
   .input_channel_field(input_channel_field), .cal_mode(cal_mode), .gain_code(gain_code), .unipolar(unipolar),
   .buffer_en(buffer_en), .filter_sync(filter_sync), .rate_select(rate_select), .clock_ctrl(clock_ctrl),
   .cal_offset(cal_offset), .cal_gain(cal_gain), .conversion_ready_flag(conversion_ready_flag));

// File: sim/tb_asra_top.sv
// Self-checking bench for the serial register access front end.
`timescale 1ns/1ps
module tb_asra_top;
   logic        core_clk, reset_n, sclk, cs_n, din, dout, result_valid;
   logic        power_down_bit, unipolar, buffer_en, filter_sync, conversion_ready_flag;
   logic [1:0]  input_channel_field, cal_mode;
   logic [2:0]  gain_code, rate_select;
   logic [4:0]  clock_ctrl;
   logic [7:0]  setup, clk_reg;
   logic [15:0] result_data;
   logic [23:0] cal_offset, cal_gain;
   logic [31:0] rx, v;
   int          err_total, cmp_count;

   asra_top u_asra_top (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .result_data(result_data), .result_valid(result_valid), .power_down_bit(power_down_bit),
      .input_channel_field(input_channel_field), .cal_mode(cal_mode), .gain_code(gain_code), .unipolar(unipolar),
      .buffer_en(buffer_en), .filter_sync(filter_sync), .rate_select(rate_select), .clock_ctrl(clock_ctrl),
      .cal_offset(cal_offset), .cal_gain(cal_gain), .conversion_ready_flag(conversion_ready_flag));
   asra_host_model u_asra_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   // Settings regrouped in register bit order.
   assign setup = {cal_mode, gain_code, unipolar, buffer_en, filter_sync};
   assign clk_reg = {clock_ctrl, rate_select};

   // Core clock at 40 MHz.
   always #12.5 core_clk = ~core_clk;

   // Compares one value and reports a difference.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("comparisons %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Command then n data bits, then a no-op keeping standby and channel so the settings cross.
   task automatic wr(input logic [7:0] cmd, input logic [23:0] data, input int n);
      u_asra_host_model.shift({cmd, 24'h0} | ({8'h0, data} << (24 - n)), 8 + n, rx);
      u_asra_host_model.shift({4'h5, 1'b0, cmd[2:0], 24'h0}, 8, rx);
      repeat (20) @(posedge core_clk);
   endtask

   // Read command, then returns the n bits shifted out behind it.
   // The first data bit leaves on the last command edge, so the frame is one edge shorter.
   task automatic rd(input logic [7:0] cmd, input int n, output logic [31:0] data);
      u_asra_host_model.shift({cmd, 24'h0}, 7 + n, rx);
      data = rx & ((32'h1 << n) - 32'h1);
   endtask

   // Keeps the link moving with no-op frames until the ready flag reaches lvl.
   task automatic wait_ready(input logic lvl);
      for (int i = 0; i < 8 && conversion_ready_flag !== lvl; i++) begin
         wr(8'h50, 24'h0, 0);
      end
      if (conversion_ready_flag !== lvl) begin
         err_total++;
         complete_run();
      end
   endtask

   // Outputs after reset.
   task automatic t_reset();
      check({power_down_bit, input_channel_field, setup, clk_reg}, {3'h0, asra_pkg::SETUP_RESET, 8'h00});
      check(conversion_ready_flag, 1'b0);
   endtask

   // Setup and clock writes, then back-to-back read back.
   task automatic t_config();
      wr(8'h10, 24'hA6, 8);
      check(setup, 8'hA6);
      wr(8'h20, 24'h5B, 8);
      check(clk_reg, 8'h5B);
      rd(8'h18, 8, v);
      check(v, 8'hA6);
      rd(8'h28, 8, v);
      check(v, 8'h5B);
      wr(8'h40, 24'h3D, 8);
      rd(8'h48, 8, v);
      check(v, 8'h3D);
   endtask

   // Standby with channel, then calibration words on pair two and pair zero.
   task automatic t_standby_cal();
      wr(8'h57, 24'h0, 0);
      check({power_down_bit, input_channel_field}, 3'h7);
      check(setup, 8'hA6);
      wr(8'h63, 24'hC35A91, 24);
      wr(8'h73, 24'h81F00E, 24);
      check(cal_offset, 24'hC35A91);
      check(cal_gain, 24'h81F00E);
      rd(8'h6B, 24, v);
      check(v, 24'hC35A91);
      rd(8'h7B, 24, v);
      check(v, 24'h81F00E);
      wr(8'h50, 24'h0, 0);
      check(cal_offset, 24'h000000);
   endtask

   // A conversion result is flagged, read MSB first, and the flag clears.
   task automatic t_result();
      @(posedge core_clk);
      #1 result_data = 16'hB2C7;
      result_valid = 1'b1;
      @(posedge core_clk);
      #1 result_valid = 1'b0;
      wait_ready(1'b1);
      check(conversion_ready_flag, 1'b1);
      rd(8'h08, 8, v);
      check(v, 8'h08);
      rd(8'h38, 16, v);
      check(v, 16'hB2C7);
      wait_ready(1'b0);
      check(conversion_ready_flag, 1'b0);
      rd(8'h08, 8, v);
      check(v, 8'h88);
      wr(8'h30, 24'h5A5A, 16);
      rd(8'h38, 16, v);
      check(v, 16'hB2C7);
   endtask

   // Access abandoned mid-word, 32 high bits, then a fresh command is obeyed.
   task automatic t_resync();
      u_asra_host_model.shift({8'h60, 8'hE7, 16'h0}, 16, rx);
      u_asra_host_model.shift(32'hFFFFFFFF, 32, rx);
      wr(8'h10, 24'h3C, 8);
      check(setup, 8'h3C);
   endtask

   // Reset for 10 cycles, then every scenario in turn.
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      result_data = 16'h0000;
      result_valid = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (10) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_config();
      t_standby_cal();
      t_result();
      t_resync();
      complete_run();
   end
endmodule

// File: src/asra_pkg.sv
// Shared constants and types of the serial register access front end.
package asra_pkg;
   // Register select codes carried by the command byte.
   localparam logic [2:0] REG_COMM   = 3'h0;
   localparam logic [2:0] REG_SETUP  = 3'h1;
   localparam logic [2:0] REG_CLOCK  = 3'h2;
   localparam logic [2:0] REG_DATA   = 3'h3;
   localparam logic [2:0] REG_TEST   = 3'h4;
   localparam logic [2:0] REG_NOP    = 3'h5;
   localparam logic [2:0] REG_OFFSET = 3'h6;
   localparam logic [2:0] REG_GAIN   = 3'h7;

   // Transfer lengths in serial clock cycles.
   localparam logic [4:0] LEN_BYTE  = 5'h08;
   localparam logic [4:0] LEN_WORD  = 5'h10;
   localparam logic [4:0] LEN_TRIPLE = 5'h18;

   // Command byte field positions.
   localparam int CMD_ZERO_BIT = 7;
   localparam int CMD_RS_LSB   = 4;
   localparam int CMD_RW_BIT   = 3;
   localparam int CMD_PWDN_BIT = 2;
   localparam int CMD_CH_LSB   = 0;
   localparam logic DIR_READ   = 1'b1;

   // Setup and clock register field positions.
   localparam int SET_MODE_LSB = 6;
   localparam int SET_GAIN_LSB = 3;
   localparam int SET_UNI_BIT  = 2;
   localparam int SET_BUF_BIT  = 1;
   localparam int SET_SYNC_BIT = 0;
   localparam int CLK_RATE_LSB = 0;
   localparam int CLK_CTRL_LSB = 3;

   // Reset values.
   localparam logic [7:0]  SETUP_RESET = 8'h01;
   localparam logic [7:0]  CLOCK_RESET = 8'h00;
   localparam logic [7:0]  TEST_RESET  = 8'h00;
   localparam logic [23:0] CAL_RESET   = 24'h000000;
   localparam logic [15:0] DATA_RESET  = 16'h0000;

   // Consecutive high input bits that force the interface back to idle.
   localparam logic [5:0] RESYNC_ONES = 6'h20;

   // Widths of the words that cross between the clock domains.
   localparam int RES_W = 16;
   localparam int CFG_W = 67;
   localparam logic [CFG_W-1:0] CFG_RESET = {1'b0, 2'h0, SETUP_RESET, CLOCK_RESET, CAL_RESET, CAL_RESET};

   // States of the serial access sequencer.
   typedef enum logic [1:0] {ASRA_IDLE, ASRA_WRITE, ASRA_READ} asra_state_t;
endpackage

// File: src/asra_top.sv
// Serial register access front end of a three channel converter.
//
// How it works
// - Eight registers, reachable only over serial port.
// - Every transaction opens with a command byte.
// - After reset, interface idles awaiting command.
// - Command selects direction and target register.
// - Reads: command, then device shifts register out.
// - Command holds standby, channel; read shows ready.
// - Setup holds mode, gain, coding, buffer.
// - Clock register holds filter and clock bits.
// - Data register presents last delivered result; one arriving while busy is dropped.
// - Per-channel calibration words, readable and writable.
// - Three-bit clock field selects update rate.
// - Access done returns interface to idle.
// - Thirty-two high input bits force idle.
// - Direction bit zero writes, one reads.
// - Standby powers down, keeps contents, serial alive.
`timescale 1ns/1ps
module asra_top (
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Serial link
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   output logic             dout,
   // Conversion results from the converter core
   input  wire logic [15:0] result_data,
   input  wire logic        result_valid,
   // Control to the converter core
   output logic             power_down_bit,
   output logic [1:0]       input_channel_field,
   output logic [1:0]       cal_mode,
   output logic [2:0]       gain_code,
   output logic             unipolar,
   output logic             buffer_en,
   output logic             filter_sync,
   output logic [2:0]       rate_select,
   output logic [4:0]       clock_ctrl,
   output logic [23:0]      cal_offset,
   output logic [23:0]      cal_gain,
   // Status
   output logic             conversion_ready_flag
);
   asra_xfer_if #(.W(asra_pkg::RES_W)) res ();
   asra_xfer_if #(.W(asra_pkg::CFG_W)) cfg ();

   // Serial domain state.
   asra_pkg::asra_state_t   state_q, state_d;
   logic [4:0]              cnt_q, cnt_d;
   logic [23:0]             sh_q, sh_d;
   logic [2:0]              tgt_q, tgt_d;
   logic                    rw_q, rw_d;
   logic                    pwdn_q, pwdn_d;
   logic [1:0]              ch_q, ch_d;
   logic [7:0]              setup_q, setup_d;
   logic [7:0]              clkreg_q, clkreg_d;
   logic [7:0]              test_q, test_d;
   logic [2:0][23:0]        off_q, off_d;
   logic [2:0][23:0]        gain_q, gain_d;
   logic [15:0]             data_q, data_d;
   logic                    ready_q, ready_d;
   logic                    dout_q, dout_d;
   logic [5:0]              ones_q, ones_d;
   logic [asra_pkg::CFG_W-1:0] sent_q, sent_d;
   logic [asra_pkg::CFG_W-1:0] cfg_word;
   logic [23:0]             shin;
   logic [7:0]              cmd_in;
   logic [1:0]              pair_now;
   logic [23:0]             rd_word;

   // Core domain state.
   logic [asra_pkg::CFG_W-1:0] cfg_q, cfg_d;
   logic [2:0]              rdy_s_q;
   logic                    rdy_q, rdy_d;

   // Transfer length of each register.
   function automatic logic [4:0] len_of(input logic [2:0] rs);
      logic [4:0] len;
      len = asra_pkg::LEN_BYTE;
      if (rs == asra_pkg::REG_DATA) begin
         len = asra_pkg::LEN_WORD;
      end else if (rs == asra_pkg::REG_OFFSET || rs == asra_pkg::REG_GAIN) begin
         len = asra_pkg::LEN_TRIPLE;
      end
      return len;
   endfunction

   // Calibration pair used by a channel code; the shorted input shares pair zero.
   function automatic logic [1:0] pair_of(input logic [1:0] ch);
      logic [1:0] p;
      p = 2'h0;
      if (ch == 2'h1) begin
         p = 2'h1;
      end else if (ch == 2'h3) begin
         p = 2'h2;
      end
      return p;
   endfunction

   assign shin     = {sh_q[22:0], din};
   assign cmd_in   = shin[7:0];
   assign pair_now = pair_of(cmd_in[asra_pkg::CMD_CH_LSB +: 2]);

   // Read word for the register named by the incoming command, MSB at the top.
   always_comb begin
      rd_word = 24'h000000;
      unique case (cmd_in[asra_pkg::CMD_RS_LSB +: 3])
         asra_pkg::REG_COMM:   rd_word = {~ready_q, cmd_in[6:0], 16'h0000};
         asra_pkg::REG_SETUP:  rd_word = {setup_q, 16'h0000};
         asra_pkg::REG_CLOCK:  rd_word = {clkreg_q, 16'h0000};
         asra_pkg::REG_DATA:   rd_word = {data_q, 8'h00};
         asra_pkg::REG_TEST:   rd_word = {test_q, 16'h0000};
         asra_pkg::REG_NOP:    rd_word = 24'h000000;
         asra_pkg::REG_OFFSET: rd_word = off_q[pair_now];
         asra_pkg::REG_GAIN:   rd_word = gain_q[pair_now];
      endcase
   end

   // Serial sequencer: command byte, then one read or write of the chosen register.
   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      sh_d     = sh_q;
      tgt_d    = tgt_q;
      rw_d     = rw_q;
      pwdn_d   = pwdn_q;
      ch_d     = ch_q;
      setup_d  = setup_q;
      clkreg_d = clkreg_q;
      test_d   = test_q;
      off_d    = off_q;
      gain_d   = gain_q;
      data_d   = data_q;
      ready_d  = ready_q;
      dout_d   = dout_q;
      ones_d   = ones_q;
      if (!cs_n) begin
         ones_d = din ? 6'(ones_q + 6'h01) : 6'h00;
         unique case (state_q)
            asra_pkg::ASRA_IDLE: begin
               dout_d = 1'b0;
               // A leading one is not clocked in, so the sequencer waits for a zero.
               if (!(cnt_q == 5'h00 && din)) begin
                  sh_d  = shin;
                  cnt_d = 5'(cnt_q + 5'h01);
                  if (cnt_q == 5'(asra_pkg::LEN_BYTE - 5'h01)) begin
                     cnt_d  = 5'h00;
                     tgt_d  = cmd_in[asra_pkg::CMD_RS_LSB +: 3];
                     rw_d   = cmd_in[asra_pkg::CMD_RW_BIT];
                     pwdn_d = cmd_in[asra_pkg::CMD_PWDN_BIT];
                     ch_d   = cmd_in[asra_pkg::CMD_CH_LSB +: 2];
                     if (cmd_in[asra_pkg::CMD_RS_LSB +: 3] == asra_pkg::REG_NOP) begin
                        state_d = asra_pkg::ASRA_IDLE;
                     end else if (cmd_in[asra_pkg::CMD_RW_BIT] == asra_pkg::DIR_READ) begin
                        state_d = asra_pkg::ASRA_READ;
                        dout_d  = rd_word[23];
                        sh_d    = {rd_word[22:0], 1'b0};
                        cnt_d   = 5'h01;
                     end else if (cmd_in[asra_pkg::CMD_RS_LSB +: 3] != asra_pkg::REG_COMM) begin
                        state_d = asra_pkg::ASRA_WRITE;
                     end
                  end
               end
            end
            asra_pkg::ASRA_WRITE: begin
               sh_d  = shin;
               cnt_d = 5'(cnt_q + 5'h01);
               if (cnt_q == 5'(len_of(tgt_q) - 5'h01)) begin
                  cnt_d   = 5'h00;
                  state_d = asra_pkg::ASRA_IDLE;
                  unique case (tgt_q)
                     asra_pkg::REG_SETUP:  setup_d = shin[7:0];
                     asra_pkg::REG_CLOCK:  clkreg_d = shin[7:0];
                     asra_pkg::REG_TEST:   test_d = shin[7:0];
                     asra_pkg::REG_OFFSET: off_d[pair_of(ch_q)] = shin;
                     asra_pkg::REG_GAIN:   gain_d[pair_of(ch_q)] = shin;
                     default:              data_d = data_q; // Result and command words are not loaded here.
                  endcase
               end
            end
            asra_pkg::ASRA_READ: begin
               dout_d = sh_q[23];
               sh_d   = {sh_q[22:0], 1'b0};
               cnt_d  = 5'(cnt_q + 5'h01);
               if (cnt_q == 5'(len_of(tgt_q) - 5'h01)) begin
                  cnt_d   = 5'h00;
                  state_d = asra_pkg::ASRA_IDLE;
                  if (tgt_q == asra_pkg::REG_DATA) begin
                     ready_d = 1'b0;
                  end
               end
            end
         endcase
         // A long run of high input bits resynchronises the interface.
         if (din && ones_q == 6'(asra_pkg::RESYNC_ONES - 6'h01)) begin
            state_d = asra_pkg::ASRA_IDLE;
            cnt_d   = 5'h00;
            ones_d  = 6'h00;
         end
      end
      // A new result wins over a clear in the same edge.
      if (res.dst_valid) begin
         data_d  = res.dst_data;
         ready_d = 1'b1;
      end
      sent_d = cfg.src_load ? cfg_word : sent_q;
   end

   // Serial domain registers; reset leaves the sequencer idle.
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q  <= asra_pkg::ASRA_IDLE;
         cnt_q    <= 5'h00;
         sh_q     <= 24'h000000;
         tgt_q    <= asra_pkg::REG_COMM;
         rw_q     <= 1'b0;
         pwdn_q   <= 1'b0;
         ch_q     <= 2'h0;
         setup_q  <= asra_pkg::SETUP_RESET;
         clkreg_q <= asra_pkg::CLOCK_RESET;
         test_q   <= asra_pkg::TEST_RESET;
         off_q    <= {3{asra_pkg::CAL_RESET}};
         gain_q   <= {3{asra_pkg::CAL_RESET}};
         data_q   <= asra_pkg::DATA_RESET;
         ready_q  <= 1'b0;
         dout_q   <= 1'b0;
         ones_q   <= 6'h00;
         sent_q   <= asra_pkg::CFG_RESET;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         sh_q     <= sh_d;
         tgt_q    <= tgt_d;
         rw_q     <= rw_d;
         pwdn_q   <= pwdn_d;
         ch_q     <= ch_d;
         setup_q  <= setup_d;
         clkreg_q <= clkreg_d;
         test_q   <= test_d;
         off_q    <= off_d;
         gain_q   <= gain_d;
         data_q   <= data_d;
         ready_q  <= ready_d;
         dout_q   <= dout_d;
         ones_q   <= ones_d;
         sent_q   <= sent_d;
      end
   end

   // Settings go to the core on a serial clock edge when they differ from the last word sent and the crossing is not busy.
   assign cfg_word     = {pwdn_q, ch_q, setup_q, clkreg_q, off_q[pair_of(ch_q)], gain_q[pair_of(ch_q)]};
   assign cfg.src_data = cfg_word;
   assign cfg.src_load = !cfg.src_busy && (cfg_word != sent_q);

   // Results are offered to the serial side; one arriving while busy is dropped.
   assign res.src_data = result_data;
   assign res.src_load = result_valid && !res.src_busy;

   asra_xfer u_res (
      .src_clk (core_clk),
      .dst_clk (sclk),
      .reset_n (reset_n),
      .x       (res)
   );

   asra_xfer u_cfg (
      .src_clk (sclk),
      .dst_clk (core_clk),
      .reset_n (reset_n),
      .x       (cfg)
   );

   // Core domain: hold the delivered settings and a settled copy of the ready flag.
   always_comb begin
      cfg_d = cfg.dst_valid ? cfg.dst_data : cfg_q;
      rdy_d = (rdy_s_q[1] == rdy_s_q[2]) ? rdy_s_q[2] : rdy_q;
   end

   // Core domain registers.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q   <= asra_pkg::CFG_RESET;
         rdy_s_q <= 3'h0;
         rdy_q   <= 1'b0;
      end else begin
         cfg_q   <= cfg_d;
         rdy_s_q <= {rdy_s_q[1:0], ready_q};
         rdy_q   <= rdy_d;
      end
   end

   // Outputs taken from registered fields.
   assign dout                  = dout_q;
   assign power_down_bit        = cfg_q[66];
   assign input_channel_field   = cfg_q[65:64];
   assign cal_mode              = cfg_q[56 + asra_pkg::SET_MODE_LSB +: 2];
   assign gain_code             = cfg_q[56 + asra_pkg::SET_GAIN_LSB +: 3];
   assign unipolar              = cfg_q[56 + asra_pkg::SET_UNI_BIT];
   assign buffer_en             = cfg_q[56 + asra_pkg::SET_BUF_BIT];
   assign filter_sync           = cfg_q[56 + asra_pkg::SET_SYNC_BIT];
   assign rate_select           = cfg_q[48 + asra_pkg::CLK_RATE_LSB +: 3];
   assign clock_ctrl            = cfg_q[48 + asra_pkg::CLK_CTRL_LSB +: 5];
   assign cal_offset            = cfg_q[47:24];
   assign cal_gain              = cfg_q[23:0];
   assign conversion_ready_flag = rdy_q;
endmodule

// File: src/asra_xfer.sv
// Toggle handshake that moves one word from a source clock to a destination clock.
`timescale 1ns/1ps
module asra_xfer (
   // Clocks and reset
   input wire logic    src_clk,
   input wire logic    dst_clk,
   input wire logic    reset_n,
   // Word channel
   asra_xfer_if.engine x
);
   localparam int W = $bits(x.src_data);

   logic         req_q, req_d;
   logic [W-1:0] data_q, data_d;
   logic [2:0]   ack_s_q;
   logic         ack_seen_q, ack_seen_d;
   logic [2:0]   req_s_q;
   logic         ack_q, ack_d;
   logic [W-1:0] out_q, out_d;
   logic         valid_q, valid_d;

   // Source side busy while a toggle is not yet acknowledged.
   assign x.src_busy = req_q ^ ack_seen_q;

   // Source side: capture the word and toggle the request; see the ack once stable.
   always_comb begin
      req_d      = req_q;
      data_d     = data_q;
      ack_seen_d = ack_seen_q;
      if (x.src_load && !x.src_busy) begin
         req_d  = ~req_q;
         data_d = x.src_data;
      end
      if (ack_s_q[1] == ack_s_q[2]) begin
         ack_seen_d = ack_s_q[2];
      end
   end

   // Source side registers, with the acknowledge synchroniser.
   always_ff @(posedge src_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q      <= 1'b0;
         data_q     <= '0;
         ack_s_q    <= 3'h0;
         ack_seen_q <= 1'b0;
      end else begin
         req_q      <= req_d;
         data_q     <= data_d;
         ack_s_q    <= {ack_s_q[1:0], ack_q};
         ack_seen_q <= ack_seen_d;
      end
   end

   // Destination side: take the held word once the request toggle has settled.
   always_comb begin
      ack_d   = ack_q;
      out_d   = out_q;
      valid_d = 1'b0;
      if (req_s_q[1] == req_s_q[2] && req_s_q[2] != ack_q) begin
         ack_d   = req_s_q[2];
         out_d   = data_q;
         valid_d = 1'b1;
      end
   end

   // Destination side registers, with the request synchroniser.
   always_ff @(posedge dst_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_s_q <= 3'h0;
         ack_q   <= 1'b0;
         out_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         req_s_q <= {req_s_q[1:0], req_q};
         ack_q   <= ack_d;
         out_q   <= out_d;
         valid_q <= valid_d;
      end
   end

   assign x.dst_data  = out_q;
   assign x.dst_valid = valid_q;
endmodule

// File: src/asra_xfer_if.sv
// Word crossing signals between the front end and its handshake engine.
`timescale 1ns/1ps
interface asra_xfer_if #(parameter int W = 8) ();
   logic [W-1:0] src_data;
   logic         src_load;
   logic         src_busy;
   logic [W-1:0] dst_data;
   logic         dst_valid;
   modport engine (input src_data, input src_load, output src_busy, output dst_data, output dst_valid);
   modport user (output src_data, output src_load, input src_busy, input dst_data, input dst_valid);
endinterface
